// >>> src/debug_trigger_status_logic.sv
// Trigger selection, run sequencing and status for the on-chip debug unit.
// Assumes comparator match inputs, access strobes, opcode-execute tag and
// FIFO store strobes come from logic on mclk; secure level is an outside pin.
// Function
// - Trigger register always readable; writes only while not armed; bits 4,5 read 0.
// - Tag select set: matches qualify only when opcode executes; clear: any access.
// - Direction bit 0 ends capture at trigger; 1 starts storage at trigger.
// - Event-only modes ignore direction bit; every run is a begin trace.
// - Mode field selects nine trigger modes; codes 1001 to 1111 never trigger.
// - Inside range is A<=addr<=B; outside range is addr<A or addr>B.
// - A hit flag clears at run start, sets on A match after arming.
// - B hit flag clears at run start, sets on B match after arming.
// - Armed status mirrors arm control while enabled; clears at run end.
// - Run completes on FIFO full in begin trace, trigger in end trace.
// - Writing 0 to arm or enable ends the run at once.
// - Valid count clears at run start, holds valid words 0 to 8 at end.
// - Valid count does not decrement when FIFO words are read out.
// - Status register is read-only; writes change nothing.
// - Event-only modes store only the low byte; high byte reads zero.
// - Break enabled: end trace breaks at trigger, begin trace at FIFO full.
// - Debug enable refuses to set while the device is secured.
`timescale 1ns/10ps
`default_nettype none

module debug_trigger_status_logic #(
	parameter int DEPTH  = dbg_trig_pkg::FIFO_DEPTH,
	parameter int AWIDTH = 16
) (
	input  wire logic              mclk,
	input  wire logic              rst_n,
	// Avalon-MM slave
	input  wire logic [4:0]        address,
	input  wire logic              read,
	input  wire logic              write,
	input  wire logic [31:0]       writedata,
	output logic      [31:0]       readdata,
	output logic                   waitrequest,
	// Processor bus observation
	input  wire logic              busValid,
	input  wire logic [AWIDTH-1:0] busAddr,
	input  wire logic [AWIDTH-1:0] compA,
	input  wire logic [AWIDTH-1:0] compB,
	input  wire logic              matchA,
	input  wire logic              matchB,
	input  wire logic              opExecA,
	input  wire logic              opExecB,
	input  wire logic              storeStrobe,
	input  wire logic [15:0]       storeData,
	input  wire logic              securePin,
	// Toward FIFO and core
	output logic                   fifoWrite,
	output logic      [15:0]       fifoData,
	output logic                   breakReq,
	output logic                   breakTag,
	output logic                   irq
);

	// ==================================================================
	// Elaboration check
	initial begin
		if (DEPTH != 8 || AWIDTH < 1)
			$error("Valid count field serves a depth of eight only");
	end

	// ==================================================================
	// Pin synchroniser for the secure level
	logic secMeta;
	logic secure;
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			secMeta <= 1'b1;
			secure  <= 1'b1;
		end else begin
			secMeta <= securePin;
			secure  <= secMeta;
		end
	end

	// ==================================================================
	// Registers and bus decode
	logic [7:0]              ctl;
	logic [7:0]              trig;
	logic                    aHit;
	logic                    bHit;
	logic [3:0]              validCount;
	logic [dbg_trig_pkg::IRQ_W-1:0] irqStat;
	logic [dbg_trig_pkg::IRQ_W-1:0] irqMask;
	dbg_trig_pkg::run_state_t runState;
	logic                    aSeen;
	logic                    beginStored;

	logic wrAccess;
	logic rdAccess;
	logic armed;
	assign wrAccess = write && !waitrequest;
	assign rdAccess = read && !waitrequest;
	assign armed    = (runState == dbg_trig_pkg::RUN_ARMED);

	function automatic logic hitOff(input logic [4:0] a, input logic [3:0] off);
		hitOff = (a == {1'b0, off});
	endfunction

	// One wait state per access: answer one cycle after the request rises
	always_ff @(posedge mclk) begin
		if (!rst_n)
			waitrequest <= 1'b1;
		else if ((read || write) && waitrequest)
			waitrequest <= 1'b0;
		else
			waitrequest <= 1'b1;
	end

	// ==================================================================
	// Trigger qualification
	dbg_trig_pkg::trig_mode_t mode;
	logic eventOnly;
	logic beginTrace;
	logic qualA;
	logic qualB;
	logic rangeIn;
	logic rangeOut;
	logic trigger;
	assign mode = dbg_trig_pkg::trig_mode_t'(trig[3:0]);
	assign eventOnly = (mode == dbg_trig_pkg::MODE_EV_B) || (mode == dbg_trig_pkg::MODE_A_THEN_EV);
	assign beginTrace = eventOnly || trig[dbg_trig_pkg::TRG_BEGIN];
	assign qualA = trig[dbg_trig_pkg::TRG_TAG] ? (matchA && opExecA) : matchA;
	assign qualB = trig[dbg_trig_pkg::TRG_TAG] ? (matchB && opExecB) : matchB;
	assign rangeIn  = busValid && (busAddr >= compA) && (busAddr <= compB);
	assign rangeOut = busValid && ((busAddr < compA) || (busAddr > compB));

	always_comb begin
		case (mode)
			dbg_trig_pkg::MODE_A_ONLY:    trigger = qualA;
			dbg_trig_pkg::MODE_A_OR_B:    trigger = qualA || qualB;
			dbg_trig_pkg::MODE_A_THEN_B:  trigger = aSeen && qualB;
			dbg_trig_pkg::MODE_EV_B:      trigger = qualB;
			dbg_trig_pkg::MODE_A_THEN_EV: trigger = aSeen && qualB;
			dbg_trig_pkg::MODE_A_AND_BD:  trigger = qualA && qualB;
			dbg_trig_pkg::MODE_A_NOT_BD:  trigger = qualA && !qualB;
			dbg_trig_pkg::MODE_INSIDE:    trigger = rangeIn;
			dbg_trig_pkg::MODE_OUTSIDE:   trigger = rangeOut;
			default:                      trigger = 1'b0;
		endcase
	end

	// ==================================================================
	// Run sequencing
	logic armWrite1;
	logic stopWrite;
	logic fifoFull;
	logic storeNow;
	logic runEnd;
	assign armWrite1 = wrAccess && hitOff(address, dbg_trig_pkg::OFF_CTL)
		&& writedata[dbg_trig_pkg::CTL_ARM] && writedata[dbg_trig_pkg::CTL_ENABLE] && !secure;
	assign stopWrite = wrAccess && hitOff(address, dbg_trig_pkg::OFF_CTL)
		&& (!writedata[dbg_trig_pkg::CTL_ARM] || !writedata[dbg_trig_pkg::CTL_ENABLE]);
	assign fifoFull = (validCount == 4'(DEPTH));
	// direction picks storage
	// In end trace the FIFO wraps; in begin trace storage waits for the trigger
	assign storeNow = armed && storeStrobe && (beginTrace ? (beginStored || trigger) && !fifoFull : 1'b1);
	assign runEnd = armed && (beginTrace ? (storeNow && validCount == 4'(DEPTH - 1)) : trigger);

	always_ff @(posedge mclk) begin
		if (!rst_n)
			runState <= dbg_trig_pkg::RUN_IDLE;
		else if (stopWrite && armed)
			runState <= dbg_trig_pkg::RUN_IDLE;
		else if (armWrite1)
			runState <= dbg_trig_pkg::RUN_ARMED;
		else if (runEnd)
			runState <= dbg_trig_pkg::RUN_DONE;
		else begin
			case (runState)
				dbg_trig_pkg::RUN_IDLE:  runState <= dbg_trig_pkg::RUN_IDLE;
				dbg_trig_pkg::RUN_ARMED: runState <= dbg_trig_pkg::RUN_ARMED;
				dbg_trig_pkg::RUN_DONE:  runState <= dbg_trig_pkg::RUN_DONE;
				default:                 runState <= dbg_trig_pkg::RUN_IDLE;
			endcase
		end
	end

	// Control register: arm bit mirrors the run
	always_ff @(posedge mclk) begin
		if (!rst_n)
			ctl <= dbg_trig_pkg::CTL_RST;
		else if (wrAccess && hitOff(address, dbg_trig_pkg::OFF_CTL)) begin
			ctl <= writedata[7:0];
			if (secure) begin
				ctl[dbg_trig_pkg::CTL_ENABLE] <= 1'b0;
				ctl[dbg_trig_pkg::CTL_ARM]    <= 1'b0;
			end
			if (!writedata[dbg_trig_pkg::CTL_ENABLE])
				ctl[dbg_trig_pkg::CTL_ARM] <= 1'b0;
		end else if (runEnd)
			ctl[dbg_trig_pkg::CTL_ARM] <= 1'b0;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n)
			trig <= dbg_trig_pkg::TRIG_RST;
		else if (wrAccess && hitOff(address, dbg_trig_pkg::OFF_TRIG) && !armed)
			trig <= writedata[7:0] & dbg_trig_pkg::TRG_WMASK;
	end

	// Sequence memory for A-then-B and the begin-trace start point
	always_ff @(posedge mclk) begin
		if (!rst_n || armWrite1) begin
			aSeen       <= 1'b0;
			beginStored <= 1'b0;
		end else if (armed) begin
			if (qualA)
				aSeen <= 1'b1;
			if (beginTrace && trigger)
				beginStored <= 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n || armWrite1) begin
			aHit <= 1'b0;
			bHit <= 1'b0;
		end else if (armed) begin
			if (qualA)
				aHit <= 1'b1;
			if (qualB)
				bHit <= 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n || armWrite1)
			validCount <= dbg_trig_pkg::CNT_RST;
		else if (storeNow && !fifoFull)
			validCount <= validCount + 4'h1;
	end

	// low byte only in event modes
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			fifoWrite <= 1'b0;
			fifoData  <= 16'h0000;
		end else begin
			fifoWrite <= storeNow;
			fifoData  <= eventOnly ? {8'h00, storeData[7:0]} : storeData;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			breakReq <= 1'b0;
			breakTag <= 1'b0;
		end else begin
			breakReq <= runEnd && ctl[dbg_trig_pkg::CTL_BREAK];
			breakTag <= trig[dbg_trig_pkg::TRG_TAG];
		end
	end

	// ==================================================================
	// Interrupt: sticky events, cleared by a read; a new event wins
	logic [dbg_trig_pkg::IRQ_W-1:0] events;
	assign events = {armed && qualB && !bHit, armed && qualA && !aHit, runEnd};
	always_ff @(posedge mclk) begin
		if (!rst_n)
			irqStat <= '0;
		else if (rdAccess && hitOff(address, dbg_trig_pkg::OFF_IRQSTAT))
			irqStat <= events;
		else
			irqStat <= irqStat | events;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n)
			irqMask <= '0;
		else if (wrAccess && address == dbg_trig_pkg::OFF_IRQMASK)
			irqMask <= writedata[dbg_trig_pkg::IRQ_W-1:0];
	end

	always_ff @(posedge mclk) begin
		if (!rst_n)
			irq <= 1'b0;
		else
			irq <= |(irqStat & irqMask);
	end

	// ==================================================================
	// Read data
	logic [7:0] statusByte;
	assign statusByte = {aHit, bHit, armed && ctl[dbg_trig_pkg::CTL_ENABLE], 1'b0, validCount};

	always_ff @(posedge mclk) begin
		if (!rst_n)
			readdata <= dbg_trig_pkg::UNMAPPED;
		else if (read && waitrequest) begin
			if (hitOff(address, dbg_trig_pkg::OFF_CTL))
				readdata <= {24'h000000, ctl};
			else if (hitOff(address, dbg_trig_pkg::OFF_TRIG))
				readdata <= {24'h000000, trig};
			else if (hitOff(address, dbg_trig_pkg::OFF_STATUS))
				readdata <= {24'h000000, statusByte};
			else if (hitOff(address, dbg_trig_pkg::OFF_IRQSTAT))
				readdata <= {29'h0, irqStat};
			else if (address == dbg_trig_pkg::OFF_IRQMASK)
				readdata <= {29'h0, irqMask};
			else
				readdata <= dbg_trig_pkg::UNMAPPED;
		end
	end

endmodule

`default_nettype wire

// >>> pkg/dbg_trig_pkg.sv
// Package for the debug trigger and status block: register map, field
// positions, reset values, trigger mode codes and FIFO depth.
// Assumes a 32-bit Avalon-MM slave port with word-aligned registers.
package dbg_trig_pkg;

	// ==================================================================
	// Register byte offsets
	localparam logic [3:0] OFF_CTL     = 4'h0;
	localparam logic [3:0] OFF_TRIG    = 4'h4;
	localparam logic [3:0] OFF_STATUS  = 4'h8;
	localparam logic [3:0] OFF_IRQSTAT = 4'hC;
	localparam int         ADDR_W      = 4;

	// ==================================================================
	// Control register bit positions
	localparam int CTL_ENABLE = 7;
	localparam int CTL_ARM    = 6;
	localparam int CTL_BREAK  = 4;

	// Trigger register bit positions
	localparam int TRG_TAG    = 7;
	localparam int TRG_BEGIN  = 6;
	localparam logic [7:0] TRG_WMASK = 8'hCF;

	// Status register bit positions
	localparam int ST_AHIT = 7;
	localparam int ST_BHIT = 6;
	localparam int ST_ARM  = 5;

	// Interrupt status / mask bits: IRQ_MASK register sits at OFF_IRQSTAT+4
	localparam logic [4:0] OFF_IRQMASK = 5'h10;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_AHIT = 1;
	localparam int IRQ_BHIT = 2;
	localparam int IRQ_W    = 3;

	// ==================================================================
	// Reset values
	localparam logic [7:0] CTL_RST  = 8'h00;
	localparam logic [7:0] TRIG_RST = 8'h00;
	localparam logic [3:0] CNT_RST  = 4'h0;

	// FIFO depth in words and unmapped read value
	localparam int         FIFO_DEPTH = 8;
	localparam logic [31:0] UNMAPPED  = 32'h0000_0000;

	// ==================================================================
	// Trigger modes
	typedef enum logic [3:0] {
		MODE_A_ONLY    = 4'h0,
		MODE_A_OR_B    = 4'h1,
		MODE_A_THEN_B  = 4'h2,
		MODE_EV_B      = 4'h3,
		MODE_A_THEN_EV = 4'h4,
		MODE_A_AND_BD  = 4'h5,
		MODE_A_NOT_BD  = 4'h6,
		MODE_INSIDE    = 4'h7,
		MODE_OUTSIDE   = 4'h8
	} trig_mode_t;

	// Run state, Gray along idle -> armed -> done
	typedef enum logic [1:0] {
		RUN_IDLE  = 2'b00,
		RUN_ARMED = 2'b01,
		RUN_DONE  = 2'b11
	} run_state_t;

endpackage

// >>> tb/dbg_trig_properties.sv
// Checker for the debug trigger block, bound to its top-level ports.
// Assumes one clock mclk and a synchronous active-low rst_n.
`timescale 1ns/10ps
`default_nettype none
module dbg_trig_properties (
	input wire logic        mclk,
	input wire logic        rst_n,
	input wire logic [4:0]  address,
	input wire logic        read,
	input wire logic        write,
	input wire logic [31:0] readdata,
	input wire logic        waitrequest,
	input wire logic        storeStrobe,
	input wire logic        fifoWrite,
	input wire logic        breakReq,
	input wire logic        breakTag,
	input wire logic        irq
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	// Read completing in this cycle
	wire logic rdOk = read && !waitrequest;
	// ==========
	// Bus handshake
	wait_answer_a: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("access not answered next cycle");
	wait_pulse_a: assert property (!waitrequest |=> waitrequest)
		else $error("waitrequest low too long");
	wait_cause_a: assert property ($fell(waitrequest) |-> $past(read || write))
		else $error("answer without request");
	// ==========
	// Register fields
	trig_zero_a: assert property (rdOk && address == 5'h04 |-> readdata[5:4] == 2'h0 && readdata[31:8] == 24'h0)
		else $error("trigger reserved bits set");
	st_bit4_a: assert property (rdOk && address == 5'h08 |-> !readdata[4])
		else $error("status bit 4 set");
	cnt_max_a: assert property (rdOk && address == 5'h08 |-> readdata[3:0] <= 4'h8)
		else $error("valid count above eight");
	// Tag copy only moves after a register write lands
	tag_hold_a: assert property ($changed(breakTag) |-> $past(write) || $past(write, 2))
		else $error("tag select moved without write");
	// ==========
	// Capture, break and interrupt
	fifo_cause_a: assert property (fifoWrite |-> $past(storeStrobe))
		else $error("fifo write without store");
	break_pulse_a: assert property (breakReq |=> !breakReq)
		else $error("break longer than a pulse");
	irq_drop_a: assert property ($fell(irq) |-> $past(read || write, 2) || $past(read || write, 3))
		else $error("irq dropped without access");
	cover property (fifoWrite);
	cover property (breakReq);
	cover property ($fell(irq));
endmodule
bind debug_trigger_status_logic dbg_trig_properties chk (.mclk, .rst_n, .address, .read, .write,
	.readdata, .waitrequest, .storeStrobe, .fifoWrite, .breakReq, .breakTag, .irq);
`default_nettype wire

// >>> tb/core_bus_model.sv
// Behavioural processor bus: comparator matches, opcode execution, stores.
// Assumes the bench moves the bus address just after a clock edge.
`timescale 1ns/10ps
`default_nettype none
module core_bus_model (
	input  wire logic        busValid,
	input  wire logic [15:0] busAddr,
	input  wire logic [15:0] compA,
	input  wire logic [15:0] compB,
	input  wire logic        execOk,
	output logic             matchA,
	output logic             matchB,
	output logic             opExecA,
	output logic             opExecB,
	output logic             storeStrobe,
	output logic      [15:0] storeData
);
	// ==========
	// Comparators follow the bus; idle data inverted so no stale word looks valid
	assign matchA = busValid && busAddr == compA;
	assign matchB = busValid && busAddr == compB;
	assign opExecA = matchA && execOk;
	assign opExecB = matchB && execOk;
	assign storeStrobe = busValid;
	assign storeData = busValid ? busAddr : ~busAddr;
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench for the debug trigger block.
// Assumes the Avalon slave answers within a few cycles.
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic        mclk = 1'b0, rst_n = 1'b0, read = 1'b0, write = 1'b0;
	logic        busValid = 1'b0, execOk = 1'b0, securePin = 1'b0;
	logic [4:0]  address = 5'h00;
	logic [31:0] writedata = 32'h0, readdata;
	logic [15:0] busAddr = 16'h0, compA = 16'h1000, compB = 16'h2000, storeData, fifoData;
	logic        waitrequest, matchA, matchB, opExecA, opExecB, storeStrobe, fifoWrite, breakReq, breakTag, irq;
	logic [7:0]  hiOr = 8'h00;
	int          err_total = 0, n_tests = 0, cyc = 0, wrCnt = 0, brkCnt = 0;
	typedef struct packed {logic [7:0] trig; logic [15:0] addr; logic ex; logic [2:0] st; logic [2:0] msk;} row_t;
	// Status expected as {A hit, B hit, armed}
	row_t rows [11] = '{'{8'h00, 16'h1000, 1'b0, 3'h4, 3'h7}, '{8'h01, 16'h2000, 1'b0, 3'h2, 3'h7},
		'{8'h02, 16'h2000, 1'b0, 3'h1, 3'h1}, '{8'h09, 16'h1000, 1'b0, 3'h1, 3'h1},
		'{8'hFF, 16'h1000, 1'b1, 3'h1, 3'h1}, '{8'h07, 16'h1000, 1'b0, 3'h0, 3'h1},
		'{8'h07, 16'h2001, 1'b0, 3'h1, 3'h1}, '{8'h08, 16'h0FFF, 1'b0, 3'h0, 3'h1},
		'{8'h08, 16'h2000, 1'b0, 3'h1, 3'h1}, '{8'h80, 16'h1000, 1'b0, 3'h1, 3'h1},
		'{8'h80, 16'h1000, 1'b1, 3'h0, 3'h1}};
	always #5 mclk = ~mclk;
	core_bus_model bus_side (.busValid, .busAddr, .compA, .compB, .execOk, .matchA, .matchB, .opExecA,
		.opExecB, .storeStrobe, .storeData);
	debug_trigger_status_logic dut (.mclk, .rst_n, .address, .read, .write, .writedata, .readdata,
		.waitrequest, .busValid, .busAddr, .compA, .compB, .matchA, .matchB, .opExecA, .opExecB,
		.storeStrobe, .storeData, .securePin, .fifoWrite, .fifoData, .breakReq, .breakTag, .irq);
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// ==========
	// Capture monitor and hang guard
	always @(posedge mclk) begin
		cyc++;
		if (fifoWrite === 1'b1) begin
			wrCnt++;
			hiOr = hiOr | fifoData[15:8];
		end
		if (breakReq === 1'b1) brkCnt++;
		if (cyc == 5000) begin
			err_total++;
			report_and_stop();
		end
	end
	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Request held until the edge that sees waitrequest low
	task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
		int n;
		n = 0;
		@(posedge mclk);
		address <= a;
		writedata <= {24'h0, d};
		write <= wr;
		read <= !wr;
		do begin
			@(posedge mclk);
			n++;
		end while (waitrequest !== 1'b0);
		q = readdata[7:0];
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		logic [7:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rc(input string nm, input logic [4:0] a, input logic [7:0] m, input logic [7:0] e);
		logic [7:0] q;
		bus(1'b0, a, 8'h00, q);
		check(nm, q & m, e);
	endtask
	task automatic pres(input logic [15:0] a, input int k);
		repeat (k) begin
			@(posedge mclk);
			busValid <= 1'b1;
			busAddr <= a;
		end
		@(posedge mclk);
		busValid <= 1'b0;
	endtask
	initial begin
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		foreach (rows[i]) begin
			wr(5'h04, rows[i].trig);
			wr(5'h00, 8'hC0);
			execOk <= rows[i].ex;
			pres(rows[i].addr, 1);
			repeat (4) @(posedge mclk);
			rc("status", 5'h08, {rows[i].msk, 5'h00}, {rows[i].st, 5'h00});
			check("irq_masked", {7'h0, irq}, 8'h00);
			check("tag", {7'h0, breakTag}, {7'h0, rows[i].trig[7]});
			wr(5'h04, 8'h0A);
			rc("trig", 5'h04, 8'hFF, rows[i].st[0] ? rows[i].trig & 8'hCF : 8'h0A);
			wr(5'h00, 8'h80);
			rc("run_active_flag", 5'h08, 8'h30, 8'h00);
		end
		$display("rows done, mismatches %0d", err_total);
		rc("irq_clr", 5'h0C, 8'h07, 8'h07);
		wr(5'h10, 8'h07);
		wr(5'h04, 8'h40);
		wr(5'h00, 8'hD0);
		wrCnt = 0;
		brkCnt = 0;
		pres(16'h1000, 1);
		pres(16'h3000, 10);
		repeat (4) @(posedge mclk);
		check("words", wrCnt[7:0], 8'h08);
		check("break", brkCnt[7:0], 8'h01);
		check("irq_on", {7'h0, irq}, 8'h01);
		rc("count", 5'h08, 8'h2F, 8'h08);
		wr(5'h08, 8'hFF);
		rc("ro", 5'h08, 8'h3F, 8'h08);
		rc("irq_st", 5'h0C, 8'h01, 8'h01);
		repeat (3) @(posedge mclk);
		check("irq_off", {7'h0, irq}, 8'h00);
		$display("begin trace done, mismatches %0d", err_total);
		wr(5'h04, 8'h03);
		wr(5'h00, 8'hC0);
		wrCnt = 0;
		hiOr = 8'h00;
		pres(16'h2000, 10);
		repeat (4) @(posedge mclk);
		check("ev_words", wrCnt[7:0], 8'h08);
		check("hibyte", hiOr, 8'h00);
		check("no_break", brkCnt[7:0], 8'h01);
		rc("kept", 5'h08, 8'h0F, 8'h08);
		securePin <= 1'b1;
		repeat (3) @(posedge mclk);
		wr(5'h00, 8'hC0);
		rc("secure", 5'h00, 8'h80, 8'h00);
		rc("unmapped", 5'h14, 8'hFF, 8'h00);
		securePin <= 1'b0;
		rst_n <= 1'b0;
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		rc("trig_rst", 5'h04, 8'hFF, 8'h00);
		rc("stat_rst", 5'h08, 8'hFF, 8'h00);
		$display("hand tests done, mismatches %0d", err_total);
		report_and_stop();
	end
endmodule
`default_nettype wire
